// ==== hw/dpbr_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dpbr_defines.vh"

module dpbr_top (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire a_en,
    input wire a_we,
    input wire [`DPBR_PORT_AW-1:0] a_addr,
    input wire [`DPBR_DATA_W-1:0] a_write_data_bus,
    input wire [`DPBR_PAR_W-1:0] a_parity_write_bus,
    input wire a_sync_output_preset,
    output wire [`DPBR_DATA_W-1:0] a_read_data_bus,
    output wire [`DPBR_PAR_W-1:0] a_parity_read_bus,
    input wire b_en,
    input wire b_we,
    input wire [`DPBR_PORT_AW-1:0] b_addr,
    input wire [`DPBR_DATA_W-1:0] b_write_data_bus,
    input wire [`DPBR_PAR_W-1:0] b_parity_write_bus,
    input wire b_sync_output_preset,
    output wire [`DPBR_DATA_W-1:0] b_read_data_bus,
    output wire [`DPBR_PAR_W-1:0] b_parity_read_bus
);

    // Number of lane-select address bits: five minus the width code.
    function [2:0] lane_bits;
        input [2:0] code;
        begin
            lane_bits = 3'h5 - code;
        end
    endfunction

    // Word index: the port address past the lane bits.
    function [`DPBR_WORD_AW-1:0] word_of;
        input [2:0] code;
        input [`DPBR_PORT_AW-1:0] addr;
        reg [`DPBR_PORT_AW-1:0] t;
        begin
            t = addr >> lane_bits(code);
            word_of = t[`DPBR_WORD_AW-1:0];
        end
    endfunction

    // Lane inside the word; lane zero is the least significant slice.
    function [4:0] lane_of;
        input [2:0] code;
        input [`DPBR_PORT_AW-1:0] addr;
        reg [`DPBR_PORT_AW-1:0] m;
        begin
            m = (14'h0001 << lane_bits(code)) - 14'h0001;
            lane_of = addr[4:0] & m[4:0];
        end
    endfunction

    // Data bits of one lane of the given width.
    function [`DPBR_DATA_W-1:0] data_mask;
        input [2:0] code;
        input [4:0] lane;
        reg [63:0] t;
        integer w;
        begin
            w = 1 << code;
            t = ((64'h0000000000000001 << w) - 64'h0000000000000001) << (lane * w);
            data_mask = t[`DPBR_DATA_W-1:0];
        end
    endfunction

    // Parity bits of one lane; narrow widths below eight bits own none.
    function [`DPBR_PAR_W-1:0] par_mask;
        input [2:0] code;
        input [4:0] lane;
        reg [7:0] t;
        integer p;
        begin
            if (code < `DPBR_WCODE_8) begin
                par_mask = 4'h0;
            end else begin
                p = 1 << (code - `DPBR_WCODE_8);
                t = ((8'h01 << p) - 8'h01) << (lane * p);
                par_mask = t[`DPBR_PAR_W-1:0];
            end
        end
    endfunction

    // Moves the low slice of a data bus up to its lane.
    function [`DPBR_DATA_W-1:0] data_place;
        input [2:0] code;
        input [4:0] lane;
        input [`DPBR_DATA_W-1:0] din;
        reg [63:0] t;
        begin
            t = {32'h00000000, din} << (lane * (1 << code));
            data_place = t[`DPBR_DATA_W-1:0] & data_mask(code, lane);
        end
    endfunction

    // Takes one lane of a stored word down to the low bits; the rest reads zero.
    function [`DPBR_DATA_W-1:0] data_pick;
        input [2:0] code;
        input [4:0] lane;
        input [`DPBR_DATA_W-1:0] word;
        begin
            data_pick = (word & data_mask(code, lane)) >> (lane * (1 << code));
        end
    endfunction

    // Parity counterparts of the two placement functions.
    function [`DPBR_PAR_W-1:0] par_place;
        input [2:0] code;
        input [4:0] lane;
        input [`DPBR_PAR_W-1:0] pin;
        reg [7:0] t;
        begin
            if (code < `DPBR_WCODE_8) begin
                par_place = 4'h0;
            end else begin
                t = {4'h0, pin} << (lane * (1 << (code - `DPBR_WCODE_8)));
                par_place = t[`DPBR_PAR_W-1:0] & par_mask(code, lane);
            end
        end
    endfunction

    function [`DPBR_PAR_W-1:0] par_pick;
        input [2:0] code;
        input [4:0] lane;
        input [`DPBR_PAR_W-1:0] word;
        begin
            if (code < `DPBR_WCODE_8) begin
                par_pick = 4'h0;
            end else begin
                par_pick = (word & par_mask(code, lane)) >>
                    (lane * (1 << (code - `DPBR_WCODE_8)));
            end
        end
    endfunction

    // Keeps a written width code inside the six legal settings.
    function [2:0] clamp_code;
        input [2:0] code;
        begin
            if (code > `DPBR_WCODE_32) begin
                clamp_code = `DPBR_WCODE_32;
            end else begin
                clamp_code = code;
            end
        end
    endfunction

    // Software-visible configuration of each port.
    reg [2:0] a_width_reg; // Port A width code, shared by its write and read buses.
    reg [2:0] b_width_reg; // Port B width code, set apart from port A.
    reg [1:0] a_mode_reg; // Port A behaviour of the output during writes.
    reg [1:0] b_mode_reg; // Port B behaviour of the output during writes.
    reg [`DPBR_DATA_W-1:0] a_output_preset_value_reg; // Port A preset data.
    reg [`DPBR_DATA_W-1:0] b_output_preset_value_reg; // Port B preset data.
    reg [`DPBR_PAR_W-1:0] a_preset_par_reg; // Port A preset parity.
    reg [`DPBR_PAR_W-1:0] b_preset_par_reg; // Port B preset parity.

    // Output latch state beside the memory read registers.
    reg a_preset_on_reg; // Port A output shows its preset value.
    reg b_preset_on_reg; // Port B output shows its preset value.
    reg [4:0] a_lane_reg; // Lane of the last port A read.
    reg [4:0] b_lane_reg; // Lane of the last port B read.
    reg [2:0] a_rcode_reg; // Width code in force at the last port A read.
    reg [2:0] b_rcode_reg; // Width code in force at the last port B read.
    reg [`DPBR_WORD_W-1:0] a_pval_reg; // Preset word caught at port A preset.
    reg [`DPBR_WORD_W-1:0] b_pval_reg; // Preset word caught at port B preset.

    // Read data of the next register access.
    reg [31:0] reg_rdata_next;

    // Request decode toward the array.
    wire a_hold;
    wire b_hold;
    wire a_ren;
    wire b_ren;
    wire [4:0] a_lane;
    wire [4:0] b_lane;
    wire [`DPBR_WORD_W-1:0] a_word_q;
    wire [`DPBR_WORD_W-1:0] b_word_q;

    assign a_lane = lane_of(a_width_reg, a_addr);
    assign b_lane = lane_of(b_width_reg, b_addr);

    // Hold mode freezes the output for every write cycle that carries no preset.
    assign a_hold = a_we && (a_mode_reg == `DPBR_MODE_HOLD);
    assign b_hold = b_we && (b_mode_reg == `DPBR_MODE_HOLD);

    // A disabled port neither reads nor writes.
    assign a_ren = a_en && !a_hold;
    assign b_ren = b_en && !b_hold;

    // The shared array; each port has its own request group.
    dpbr_mem u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .a_ren(a_ren),
        .a_we(a_en && a_we),
        .a_new_first(a_mode_reg != `DPBR_MODE_OLD),
        .a_addr(word_of(a_width_reg, a_addr)),
        .a_mask({par_mask(a_width_reg, a_lane), data_mask(a_width_reg, a_lane)}),
        .a_wdata({par_place(a_width_reg, a_lane, a_parity_write_bus),
                  data_place(a_width_reg, a_lane, a_write_data_bus)}),
        .a_rdata(a_word_q),
        .b_ren(b_ren),
        .b_we(b_en && b_we),
        .b_new_first(b_mode_reg != `DPBR_MODE_OLD),
        .b_addr(word_of(b_width_reg, b_addr)),
        .b_mask({par_mask(b_width_reg, b_lane), data_mask(b_width_reg, b_lane)}),
        .b_wdata({par_place(b_width_reg, b_lane, b_parity_write_bus),
                  data_place(b_width_reg, b_lane, b_write_data_bus)}),
        .b_rdata(b_word_q)
    );

    // Port A output latch control: preset wins over a read on the same edge.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_preset_on_reg <= 1'b0;
            a_lane_reg <= 5'h00;
            a_rcode_reg <= `DPBR_CFG_WIDTH_RST;
            a_pval_reg <= {`DPBR_WORD_W{1'b0}};
        end else if (a_en) begin
            if (a_sync_output_preset) begin
                a_preset_on_reg <= 1'b1;
                a_pval_reg <= {a_preset_par_reg, a_output_preset_value_reg};
            end else if (a_ren) begin
                a_preset_on_reg <= 1'b0;
                a_lane_reg <= a_lane;
                a_rcode_reg <= a_width_reg;
            end
        end
    end

    // Port B output latch control, kept apart from port A.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            b_preset_on_reg <= 1'b0;
            b_lane_reg <= 5'h00;
            b_rcode_reg <= `DPBR_CFG_WIDTH_RST;
            b_pval_reg <= {`DPBR_WORD_W{1'b0}};
        end else if (b_en) begin
            if (b_sync_output_preset) begin
                b_preset_on_reg <= 1'b1;
                b_pval_reg <= {b_preset_par_reg, b_output_preset_value_reg};
            end else if (b_ren) begin
                b_preset_on_reg <= 1'b0;
                b_lane_reg <= b_lane;
                b_rcode_reg <= b_width_reg;
            end
        end
    end

    // Outputs are a mux of flip-flops, settled right after the edge.
    // The preset word is shown whole; software sets it to suit the width.
    assign a_read_data_bus = a_preset_on_reg ? a_pval_reg[`DPBR_DATA_W-1:0] :
        data_pick(a_rcode_reg, a_lane_reg, a_word_q[`DPBR_DATA_W-1:0]);
    assign a_parity_read_bus = a_preset_on_reg ? a_pval_reg[`DPBR_WORD_W-1:`DPBR_DATA_W] :
        par_pick(a_rcode_reg, a_lane_reg, a_word_q[`DPBR_WORD_W-1:`DPBR_DATA_W]);
    assign b_read_data_bus = b_preset_on_reg ? b_pval_reg[`DPBR_DATA_W-1:0] :
        data_pick(b_rcode_reg, b_lane_reg, b_word_q[`DPBR_DATA_W-1:0]);
    assign b_parity_read_bus = b_preset_on_reg ? b_pval_reg[`DPBR_WORD_W-1:`DPBR_DATA_W] :
        par_pick(b_rcode_reg, b_lane_reg, b_word_q[`DPBR_WORD_W-1:`DPBR_DATA_W]);

    // Configuration writes; a change takes effect on the next port edge.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_width_reg <= `DPBR_CFG_WIDTH_RST;
            b_width_reg <= `DPBR_CFG_WIDTH_RST;
            a_mode_reg <= `DPBR_CFG_MODE_RST;
            b_mode_reg <= `DPBR_CFG_MODE_RST;
            a_preset_par_reg <= `DPBR_PPAR_RST;
            b_preset_par_reg <= `DPBR_PPAR_RST;
            a_output_preset_value_reg <= `DPBR_PRESET_RST;
            b_output_preset_value_reg <= `DPBR_PRESET_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `DPBR_CFG_A_OFS: begin
                    a_width_reg <= clamp_code(
                        reg_wdata[`DPBR_CFG_WIDTH_MSB:`DPBR_CFG_WIDTH_LSB]);
                    a_mode_reg <= reg_wdata[`DPBR_CFG_MODE_MSB:`DPBR_CFG_MODE_LSB];
                    a_preset_par_reg <= reg_wdata[`DPBR_CFG_PPAR_MSB:`DPBR_CFG_PPAR_LSB];
                end
                `DPBR_CFG_B_OFS: begin
                    b_width_reg <= clamp_code(
                        reg_wdata[`DPBR_CFG_WIDTH_MSB:`DPBR_CFG_WIDTH_LSB]);
                    b_mode_reg <= reg_wdata[`DPBR_CFG_MODE_MSB:`DPBR_CFG_MODE_LSB];
                    b_preset_par_reg <= reg_wdata[`DPBR_CFG_PPAR_MSB:`DPBR_CFG_PPAR_LSB];
                end
                `DPBR_PRESET_A_OFS: begin
                    a_output_preset_value_reg <= reg_wdata;
                end
                `DPBR_PRESET_B_OFS: begin
                    b_output_preset_value_reg <= reg_wdata;
                end
                default: begin
                    // Writes to other offsets are dropped.
                end
            endcase
        end
    end

    // Read decode; unmapped offsets and reserved bits read as zero.
    always @* begin
        reg_rdata_next = 32'h00000000;
        case (reg_addr)
            `DPBR_CFG_A_OFS: begin
                reg_rdata_next[`DPBR_CFG_WIDTH_MSB:`DPBR_CFG_WIDTH_LSB] = a_width_reg;
                reg_rdata_next[`DPBR_CFG_MODE_MSB:`DPBR_CFG_MODE_LSB] = a_mode_reg;
                reg_rdata_next[`DPBR_CFG_PPAR_MSB:`DPBR_CFG_PPAR_LSB] = a_preset_par_reg;
            end
            `DPBR_CFG_B_OFS: begin
                reg_rdata_next[`DPBR_CFG_WIDTH_MSB:`DPBR_CFG_WIDTH_LSB] = b_width_reg;
                reg_rdata_next[`DPBR_CFG_MODE_MSB:`DPBR_CFG_MODE_LSB] = b_mode_reg;
                reg_rdata_next[`DPBR_CFG_PPAR_MSB:`DPBR_CFG_PPAR_LSB] = b_preset_par_reg;
            end
            `DPBR_PRESET_A_OFS: begin
                reg_rdata_next = a_output_preset_value_reg;
            end
            `DPBR_PRESET_B_OFS: begin
                reg_rdata_next = b_output_preset_value_reg;
            end
            `DPBR_STATUS_OFS: begin
                reg_rdata_next[0] = a_preset_on_reg;
                reg_rdata_next[1] = b_preset_on_reg;
                reg_rdata_next[6:4] = a_rcode_reg;
                reg_rdata_next[10:8] = b_rcode_reg;
            end
            default: begin
                reg_rdata_next = 32'h00000000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe, zero otherwise.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= reg_rdata_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ==== hw/dpbr_defines.vh ====
`ifndef DPBR_DEFINES_VH
`define DPBR_DEFINES_VH

// Register byte offsets on the configuration port.
`define DPBR_CFG_A_OFS 8'h00
`define DPBR_CFG_B_OFS 8'h04
`define DPBR_PRESET_A_OFS 8'h08
`define DPBR_PRESET_B_OFS 8'h0C
`define DPBR_STATUS_OFS 8'h10

// Field positions inside a port configuration word.
`define DPBR_CFG_WIDTH_LSB 0
`define DPBR_CFG_WIDTH_MSB 2
`define DPBR_CFG_MODE_LSB 4
`define DPBR_CFG_MODE_MSB 5
`define DPBR_CFG_PPAR_LSB 8
`define DPBR_CFG_PPAR_MSB 11

// Data width codes: the width in bits is two to the power of the code.
`define DPBR_WCODE_1 3'h0
`define DPBR_WCODE_8 3'h3
`define DPBR_WCODE_32 3'h5

// Write access modes.
`define DPBR_MODE_NEW 2'h0
`define DPBR_MODE_OLD 2'h1
`define DPBR_MODE_HOLD 2'h2

// Reset values of the configuration registers.
`define DPBR_CFG_WIDTH_RST 3'h5
`define DPBR_CFG_MODE_RST 2'h0
`define DPBR_PRESET_RST 32'h00000000
`define DPBR_PPAR_RST 4'h0

// Array geometry: 512 words of 32 data bits plus 4 parity bits.
`define DPBR_WORD_AW 9
`define DPBR_DATA_W 32
`define DPBR_PAR_W 4
`define DPBR_WORD_W 36
`define DPBR_DEPTH 512
`define DPBR_PORT_AW 14

`endif

// ==== hw/dpbr_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dpbr_defines.vh"

// Two-port word array with per-bit write masks and registered read data.
module dpbr_mem (
    input wire clk,
    input wire rst_b,
    input wire a_ren,
    input wire a_we,
    input wire a_new_first,
    input wire [`DPBR_WORD_AW-1:0] a_addr,
    input wire [`DPBR_WORD_W-1:0] a_mask,
    input wire [`DPBR_WORD_W-1:0] a_wdata,
    output reg [`DPBR_WORD_W-1:0] a_rdata,
    input wire b_ren,
    input wire b_we,
    input wire b_new_first,
    input wire [`DPBR_WORD_AW-1:0] b_addr,
    input wire [`DPBR_WORD_W-1:0] b_mask,
    input wire [`DPBR_WORD_W-1:0] b_wdata,
    output reg [`DPBR_WORD_W-1:0] b_rdata
);

    // Storage array; contents are never cleared, so no reset.
    reg [`DPBR_WORD_W-1:0] mem [0:`DPBR_DEPTH-1];

    // Merged words that a masked write would leave behind.
    wire [`DPBR_WORD_W-1:0] a_merged;
    wire [`DPBR_WORD_W-1:0] b_merged;

    assign a_merged = (mem[a_addr] & ~a_mask) | (a_wdata & a_mask);
    assign b_merged = (mem[b_addr] & ~b_mask) | (b_wdata & b_mask);

    // Masked writes; on a same-word clash port B lands last.
    always @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_merged;
        end
        if (b_we) begin
            mem[b_addr] <= b_merged;
        end
    end

    // Port A read register: old word unless new data is asked for.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_rdata <= {`DPBR_WORD_W{1'b0}};
        end else if (a_ren) begin
            if (a_we && a_new_first) begin
                a_rdata <= a_merged;
            end else begin
                a_rdata <= mem[a_addr];
            end
        end
    end

    // Port B read register, built the same way as port A.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            b_rdata <= {`DPBR_WORD_W{1'b0}};
        end else if (b_ren) begin
            if (b_we && b_new_first) begin
                b_rdata <= b_merged;
            end else begin
                b_rdata <= mem[b_addr];
            end
        end
    end

endmodule
`default_nettype wire

// ==== test/dpbr_fabric.sv ====
`timescale 1ns/1ps
`default_nettype none
// Fabric logic driving one memory port.
module dpbr_fabric (
    input wire clk,
    output logic en,
    output logic we,
    output logic preset,
    output logic [13:0] addr,
    output logic [31:0] wdata,
    output logic [3:0] wpar,
    input wire [31:0] rdata,
    input wire [3:0] rpar
);
    // Idle until the first request.
    initial begin
        {en, we, preset} = 3'h0;
        {addr, wdata, wpar} = 50'h0;
    end

    // One port cycle, then idle; the caller never overlaps ports.
    task op(input e, input w, input p, input [13:0] a, input [31:0] d,
            input [3:0] dp, output [31:0] q, output [3:0] qp);
        @(posedge clk);
        {en, we, preset} <= {e, w, p};
        {addr, wdata, wpar} <= {a, d, dp};
        @(posedge clk);
        {en, we, preset} <= 3'h0;
        // Released lines show the inverse, never stale data.
        {addr, wdata, wpar} <= ~{a, d, dp};
        #1;
        q = rdata;
        qp = rpar;
    endtask
endmodule
`default_nettype wire

// ==== test/dpbr_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpbr_defines.vh"

// Checker on the top ports; it shadows the bus configuration.
module dpbr_chk (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire a_en,
    input wire a_we,
    input wire [31:0] a_write_data_bus,
    input wire [3:0] a_parity_write_bus,
    input wire a_sync_output_preset,
    input wire [31:0] a_read_data_bus,
    input wire [3:0] a_parity_read_bus,
    input wire b_en,
    input wire b_we,
    input wire b_sync_output_preset,
    input wire [31:0] b_read_data_bus,
    input wire [3:0] b_parity_read_bus
);
    reg [2:0] wa_reg; // Width code of port A.
    reg [2:0] wb_reg; // Width code of port B.
    reg [1:0] ma_reg; // Write mode of port A.
    reg [3:0] ppa_reg; // Preset parity of port A.
    reg [3:0] ppb_reg; // Preset parity of port B.
    reg [31:0] pa_reg; // Preset word of port A.
    reg [31:0] pb_reg; // Preset word of port B.
    reg [2:0] rb_reg; // Width of port B at its last read.

    // Codes above 5 fold to the widest setting.
    function [2:0] wfix(input [2:0] c);
        wfix = (c > 3'h5) ? 3'h5 : c;
    endfunction
    function [31:0] dmask(input [2:0] c);
        dmask = 32'hFFFFFFFF >> (32 - (1 << c));
    endfunction
    // Narrow widths carry no parity at all.
    function [3:0] pmask(input [2:0] c);
        pmask = (c < 3'h3) ? 4'h0 : (4'hF >> (4 - (1 << (c - 3))));
    endfunction

    // Shadow configuration, updated with the block.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wa_reg <= 3'h5;
            wb_reg <= 3'h5;
            ma_reg <= 2'h0;
            ppa_reg <= 4'h0;
            ppb_reg <= 4'h0;
            pa_reg <= 32'h00000000;
            pb_reg <= 32'h00000000;
            rb_reg <= 3'h5;
        end else begin
            if (reg_wr && reg_addr == `DPBR_CFG_A_OFS) begin
                wa_reg <= wfix(reg_wdata[2:0]);
                ma_reg <= reg_wdata[5:4];
                ppa_reg <= reg_wdata[11:8];
            end
            if (reg_wr && reg_addr == `DPBR_CFG_B_OFS) begin
                wb_reg <= wfix(reg_wdata[2:0]);
                ppb_reg <= reg_wdata[11:8];
            end
            if (reg_wr && reg_addr == `DPBR_PRESET_A_OFS) begin
                pa_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == `DPBR_PRESET_B_OFS) begin
                pb_reg <= reg_wdata;
            end
            if (b_en && !b_we && !b_sync_output_preset) begin
                rb_reg <= wb_reg;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_porta_idle_hold: assert property (!a_en |=> $stable(a_read_data_bus) &&
        $stable(a_parity_read_bus)) else $error("A moved while off");
    a_portb_idle_hold: assert property (!b_en |=> $stable(b_read_data_bus) &&
        $stable(b_parity_read_bus)) else $error("B moved while off");
    a_reg_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("stray read data");
    a_unmapped_read_zero: assert property (reg_rd && reg_addr > 8'h10 |=> reg_rdata == 32'h0)
        else $error("unmapped read");
    a_portb_read_width: assert property (b_en && !b_we && !b_sync_output_preset |=>
        (b_read_data_bus & ~dmask(rb_reg)) == 32'h0 && (b_parity_read_bus & ~pmask(rb_reg)) == 4'h0)
        else $error("B bits past width");
    a_porta_preset_value: assert property (a_en && a_sync_output_preset |=>
        a_read_data_bus == $past(pa_reg) && a_parity_read_bus == $past(ppa_reg))
        else $error("A preset wrong");
    a_portb_preset_value: assert property (b_en && b_sync_output_preset |=>
        b_read_data_bus == $past(pb_reg) && b_parity_read_bus == $past(ppb_reg))
        else $error("B preset wrong");
    a_porta_hold_mode: assert property (a_en && a_we && !a_sync_output_preset &&
        ma_reg == `DPBR_MODE_HOLD |=> $stable(a_read_data_bus) && $stable(a_parity_read_bus))
        else $error("A moved in hold");
    a_porta_new_data: assert property (a_en && a_we && !a_sync_output_preset &&
        (ma_reg == 2'h0 || ma_reg == 2'h3) |=>
        a_read_data_bus == ($past(a_write_data_bus) & dmask($past(wa_reg))) &&
        a_parity_read_bus == ($past(a_parity_write_bus) & pmask($past(wa_reg))))
        else $error("A new data wrong");

    c_porta_preset: cover property (a_en && a_sync_output_preset);
    c_portb_preset: cover property (b_en && b_sync_output_preset);
    c_porta_hold: cover property (a_en && a_we && ma_reg == `DPBR_MODE_HOLD);
endmodule

bind dpbr_top dpbr_chk u_dpbr_chk (.*);
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dpbr_defines.vh"

// Register bus tasks and one fabric model per port.
module testbench;
    logic clk, rst_b, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, q;
    logic [3:0] qp;
    wire [31:0] reg_rdata, a_q, b_q, a_d, b_d;
    wire [3:0] a_qp, b_qp, a_dp, b_dp;
    wire a_en, a_we, a_pr, b_en, b_we, b_pr;
    wire [13:0] a_ad, b_ad;
    int err_total = 0;
    int tests_run = 0;

    dpbr_top u_dpbr_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .a_en(a_en), .a_we(a_we), .a_addr(a_ad), .a_write_data_bus(a_d),
        .a_parity_write_bus(a_dp), .a_sync_output_preset(a_pr), .a_read_data_bus(a_q),
        .a_parity_read_bus(a_qp), .b_en(b_en), .b_we(b_we), .b_addr(b_ad),
        .b_write_data_bus(b_d), .b_parity_write_bus(b_dp), .b_sync_output_preset(b_pr),
        .b_read_data_bus(b_q), .b_parity_read_bus(b_qp));
    dpbr_fabric u_dpbr_fabric_a (.clk(clk), .en(a_en), .we(a_we), .preset(a_pr),
        .addr(a_ad), .wdata(a_d), .wpar(a_dp), .rdata(a_q), .rpar(a_qp));
    dpbr_fabric u_dpbr_fabric_b (.clk(clk), .en(b_en), .we(b_we), .preset(b_pr),
        .addr(b_ad), .wdata(b_d), .wpar(b_dp), .rdata(b_q), .rpar(b_qp));

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Counts comparisons and reports mismatches.
    task chk(input string nm, input [31:0] e, input [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    endtask

    // One-cycle register write strobe.
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe.
    task rd_chk(input string nm, input [7:0] a, input [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask

    // Shorthands: a read on port B and a write on port A.
    task rd_b(input [13:0] a);
        u_dpbr_fabric_b.op(1, 0, 0, a, 32'h0, 4'h0, q, qp);
    endtask
    task wr_a(input [13:0] a, input [31:0] d, input [3:0] dp);
        u_dpbr_fabric_a.op(1, 1, 0, a, d, dp, q, qp);
    endtask

    // Reset values, unmapped place, folded width.
    task t_regs;
        rd_chk("cfg_a", `DPBR_CFG_A_OFS, 32'h00000005);
        rd_chk("preset_b", `DPBR_PRESET_B_OFS, 32'h00000000);
        rd_chk("unmapped", 8'h20, 32'h00000000);
        wr(`DPBR_CFG_B_OFS, 32'h00000007);
        rd_chk("fold", `DPBR_CFG_B_OFS, 32'h00000005);
    endtask

    // Wide write on A, read back on B.
    task t_wide;
        wr_a(14'h0003, 32'h12345678, 4'hA);
        chk("a_new", 32'h12345678, q);
        chk("a_new_p", 32'hA, {28'h0, qp});
        rd_b(14'h0003);
        chk("b_read", 32'h12345678, q);
        chk("b_read_p", 32'hA, {28'h0, qp});
    endtask

    // Bytes on A join into one word on B.
    task t_narrow;
        int i;
        wr(`DPBR_CFG_A_OFS, {29'h0, `DPBR_WCODE_8});
        for (i = 0; i < 4; i++) begin
            wr_a(14'd20 + i[13:0], {24'hFFFFFF, 8'h11 * (i[7:0] + 1)}, 4'hD >> i);
            chk("a_byte", {24'h0, 8'h11 * (i[7:0] + 1)}, q);
            chk("a_byte_p", {31'h0, 4'hD >> i} & 32'h1, {28'h0, qp});
        end
        rd_b(14'h0005);
        chk("b_join", 32'h44332211, q);
        chk("b_join_p", 32'hD, {28'h0, qp});
    endtask

    // Wide words on A read as halves and bits on B.
    task t_split;
        wr(`DPBR_CFG_A_OFS, {29'h0, `DPBR_WCODE_32});
        wr_a(14'h0007, 32'hCAFEF00D, 4'h6);
        wr_a(14'h01FF, 32'h80000000, 4'h0);
        wr(`DPBR_CFG_B_OFS, 32'h00000004);
        rd_b(14'h3C0E);
        chk("b_lo", 32'h0000F00D, q);
        chk("b_lo_p", 32'h2, {28'h0, qp});
        rd_b(14'h000F);
        chk("b_hi", 32'h0000CAFE, q);
        chk("b_hi_p", 32'h1, {28'h0, qp});
        wr(`DPBR_CFG_B_OFS, {29'h0, `DPBR_WCODE_1});
        rd_b(14'd225);
        chk("b_bit", 32'h0, q);
        rd_b(14'h3FFF);
        chk("b_top_bit", 32'h1, q);
        chk("b_bit_p", 32'h0, {28'h0, qp});
    endtask

    // New, old and hold modes on the same word.
    task t_modes;
        wr_a(14'h0002, 32'h11111111, 4'h0);
        wr(`DPBR_CFG_A_OFS, 32'h00000015);
        wr_a(14'h0002, 32'h22222222, 4'h0);
        chk("a_old", 32'h11111111, q);
        wr(`DPBR_CFG_A_OFS, 32'h00000025);
        wr_a(14'h0002, 32'h33333333, 4'h0);
        chk("a_hold", 32'h11111111, q);
        u_dpbr_fabric_a.op(1, 0, 0, 14'h0002, 32'h0, 4'h0, q, qp);
        chk("a_stored", 32'h33333333, q);
    endtask

    // Preset on B, disabled edge, word intact.
    task t_preset;
        wr(`DPBR_PRESET_B_OFS, 32'hA55A0FF0);
        wr(`DPBR_CFG_B_OFS, 32'h00000905);
        u_dpbr_fabric_b.op(1, 0, 1, 14'h0002, 32'h0, 4'h0, q, qp);
        chk("b_preset", 32'hA55A0FF0, q);
        chk("b_preset_p", 32'h9, {28'h0, qp});
        rd_chk("status", `DPBR_STATUS_OFS, 32'h00000052);
        u_dpbr_fabric_b.op(0, 1, 1, 14'h0002, 32'h0, 4'h0, q, qp);
        chk("b_off", 32'hA55A0FF0, q);
        rd_b(14'h0002);
        chk("b_intact", 32'h33333333, q);
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        end_sim;
    end

    // Main sequence.
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_wide;
        t_narrow;
        t_split;
        t_modes;
        t_preset;
        end_sim;
    end
endmodule
`default_nettype wire
